/* rtl/tcr_timer.sv */
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "tcr_defs.svh"
module tcr_timer
   import tcr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // divided counter clock, one-cycle pulse
   input wire logic count_tick,
   // compare/capture events from the circuits
   input wire logic [5:0] cc_event,
   input wire logic [5:0] cc_overwrite_event,
   // capture pins
   input wire logic [5:0] capture_input_pin,
   // channel outputs
   output logic channel_enable,
   output logic [15:0] current_count,
   output logic [95:0] cc_control,
   output logic irq
);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   logic run_r; // counting
   logic preset_r; // counter reset pending
   logic oneshot_r; // single pass select
   tcr_dir_t dir_sel_r; // count direction select
   logic dir_up_r; // live direction in up/down mode
   logic [15:0] flag_r; // interrupt flags
   logic [15:0] inte_r; // interrupt enables
   logic [15:0] cc_ctl_r [0:5]; // compare/capture control words
   logic [15:0] cnt_nxt; // next counter value
   logic dir_nxt; // next up/down direction
   logic moved; // counter stepped this cycle
   logic ev_max; // counter reached max
   logic ev_zero; // counter reached zero
   logic os_stop; // one-shot end
   logic tick_on; // gated counter tick
   logic [15:0] max_val; // loaded max period
   logic mc_busy; // period load busy
   logic [15:0] mc_shadow_r; // last written period
   logic [5:0] cap_level; // synchronised pin levels
   logic setup; // apb setup phase
   logic wr_acc; // write taken this edge
   logic [31:0] rd_data; // read mux
   logic rd_err; // unmapped address
   logic updn_stat; // direction status
   logic [15:0] flag_set; // hardware flag sets
   logic [15:0] flag_clr; // software flag clears
   logic cc_hit; // address in compare/capture block
   logic [2:0] cc_idx; // compare/capture index

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------

   // channel clock gate: nothing counts while the channel is off
   assign tick_on = count_tick & channel_enable; // see [R9]
   assign setup = psel & ~penable;
   // pready is registered, so this is the one edge that takes a write
   assign wr_acc = psel & penable & pready & pwrite & ~pslverr;
   assign cc_hit = (paddr[11:5] == 7'(`TCR_OFS_CC_BASE >> 5));
   assign cc_idx = paddr[4:2];

   // -----------------------------------------------------------------
   // submodules
   // -----------------------------------------------------------------

   // capture pins cross into the bus clock
   tcr_cap_sync u_sync
   (
      .clk(clk),
      .rst(rst),
      .pin_async(capture_input_pin),
      .pin_level(cap_level)
   );

   // period register load handshake
   tcr_period_load u_load
   (
      .clk(clk),
      .rst(rst),
      .wr(wr_acc && paddr == `TCR_OFS_MC),
      .wdata(pwdata[15:0]),
      .enable(channel_enable),
      .tick(count_tick),
      .busy(mc_busy),
      .max_value(max_val)
   );

   // -----------------------------------------------------------------
   // counter next state
   // -----------------------------------------------------------------

   // preset beats counting on the same tick
   always_comb
   begin
      cnt_nxt = current_count;
      dir_nxt = dir_up_r;
      moved = 1'b0;
      if (tick_on && preset_r)
      begin
         // down mode presets to max, the others to zero
         if (dir_sel_r == TCR_DIR_DOWN)
         begin
            cnt_nxt = max_val; // see [R7]
            dir_nxt = 1'b0;
         end
         else
         begin
            cnt_nxt = 16'h0000; // see [R6]
            dir_nxt = 1'b1;
         end
      end
      else if (tick_on && run_r)
      begin
         unique case (dir_sel_r) // see [R2]
            TCR_DIR_UP:
            begin
               // wrap to zero after max
               moved = 1'b1;
               dir_nxt = 1'b1;
               cnt_nxt = (current_count == max_val) ? 16'h0000 : current_count + 16'h0001; // see [R25]
            end
            TCR_DIR_DOWN:
            begin
               // wrap to max after zero
               moved = 1'b1;
               dir_nxt = 1'b0;
               cnt_nxt = (current_count == 16'h0000) ? max_val : current_count - 16'h0001; // see [R25]
            end
            TCR_DIR_UPDN:
            begin
               // turn round at both ends
               moved = 1'b1;
               if (dir_up_r && current_count != max_val)
                  cnt_nxt = current_count + 16'h0001;
               else if (dir_up_r)
               begin
                  cnt_nxt = current_count - 16'h0001;
                  dir_nxt = 1'b0;
               end
               else if (current_count != 16'h0000)
                  cnt_nxt = current_count - 16'h0001;
               else
               begin
                  cnt_nxt = current_count + 16'h0001;
                  dir_nxt = 1'b1;
               end
            end
            default:
            begin
               // reserved code holds the counter
               moved = 1'b0;
            end
         endcase
      end
   end

   // end events come from where the counter lands
   assign ev_max = moved && cnt_nxt == max_val; // see [R23]
   assign ev_zero = moved && cnt_nxt == 16'h0000; // see [R24]

   // up one-shot ends at max; down and up/down end at zero
   assign os_stop = oneshot_r && ((dir_sel_r == TCR_DIR_UP) ? ev_max : ev_zero);

   // -----------------------------------------------------------------
   // counter and direction
   // -----------------------------------------------------------------

   // live count register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         current_count <= `TCR_TC_RESET; // see [R13]
         dir_up_r <= 1'b1;
      end
      else
      begin
         current_count <= cnt_nxt;
         dir_up_r <= dir_nxt;
      end
   end

   // -----------------------------------------------------------------
   // counter control register
   // -----------------------------------------------------------------

   // mode and channel enable fields
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         channel_enable <= 1'b0;
         oneshot_r <= 1'b0;
         dir_sel_r <= TCR_DIR_UP;
      end
      else if (wr_acc && paddr == `TCR_OFS_CTL)
      begin
         channel_enable <= pwdata[`TCR_CTL_EN]; // see [R9]
         oneshot_r <= pwdata[`TCR_CTL_ONESHOT]; // see [R2]
         dir_sel_r <= tcr_dir_t'(pwdata[`TCR_CTL_DIR_HI:`TCR_CTL_DIR_LO]);
      end
   end

   // run bit: software write wins over the one-shot end
   always_ff @(posedge clk)
   begin
      if (rst)
         run_r <= 1'b0;
      else if (wr_acc && paddr == `TCR_OFS_CTL &&
               (pwdata[`TCR_CTL_EN] || channel_enable || !pwdata[`TCR_CTL_RUN]))
         run_r <= pwdata[`TCR_CTL_RUN]; // see [R3] see [R4]
      else if (os_stop)
         run_r <= 1'b0; // see [R5]
   end

   // preset request: writing 0 leaves a pending preset alone
   always_ff @(posedge clk)
   begin
      if (rst)
         preset_r <= 1'b0;
      else if (wr_acc && paddr == `TCR_OFS_CTL && pwdata[`TCR_CTL_PRESET] &&
               (pwdata[`TCR_CTL_EN] || channel_enable))
         preset_r <= 1'b1; // see [R6] see [R8]
      else if (tick_on)
         preset_r <= 1'b0; // see [R8]
   end

   // read-back copy of the period register
   always_ff @(posedge clk)
   begin
      if (rst)
         mc_shadow_r <= `TCR_MC_RESET; // see [R10]
      else if (wr_acc && paddr == `TCR_OFS_MC && !mc_busy)
         mc_shadow_r <= pwdata[15:0];
   end

   // -----------------------------------------------------------------
   // interrupt flags and enables
   // -----------------------------------------------------------------

   // causes placed at zero, max, then pairs per circuit
   always_comb
   begin
      flag_set = 16'h0000;
      flag_set[0] = ev_zero; // see [R18]
      flag_set[1] = ev_max;
      for (int m = 0; m < `TCR_NUM_CC; m++)
      begin
         flag_set[2 * m + 2] = cc_event[m];
         flag_set[2 * m + 3] = cc_overwrite_event[m];
      end
   end

   assign flag_clr = (wr_acc && paddr == `TCR_OFS_INTF) ? pwdata[15:0] : 16'h0000;

   // a cause in the clearing cycle survives the clear
   always_ff @(posedge clk)
   begin
      if (rst)
         flag_r <= 16'h0000;
      else
         flag_r <= ((flag_r & ~flag_clr) | flag_set) & `TCR_FLAG_BUILT; // see [R17] see [R19]
   end

   // enables only exist for built circuits
   always_ff @(posedge clk)
   begin
      if (rst)
         inte_r <= 16'h0000;
      else if (wr_acc && paddr == `TCR_OFS_INTE)
         inte_r <= pwdata[15:0] & `TCR_FLAG_BUILT; // see [R20] see [R19]
   end

   // request follows the enabled flags one cycle later
   always_ff @(posedge clk)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(flag_r & inte_r); // see [R22]
   end

   // -----------------------------------------------------------------
   // compare/capture control words
   // -----------------------------------------------------------------

   // one word per circuit; absent ones stay zero
   genvar gc;
   generate
      for (gc = 0; gc < `TCR_NUM_CC; gc = gc + 1)
      begin : g_cc
         always_ff @(posedge clk)
         begin
            if (rst)
               cc_ctl_r[gc] <= 16'h0000;
            else if (wr_acc && cc_hit && cc_idx == 3'(gc) && ((`TCR_CC_BUILT >> gc) & 6'h01) != 6'h00)
               cc_ctl_r[gc] <= pwdata[15:0] & `TCR_CCCTL_MASK;
         end
         assign cc_control[16 * gc +: 16] = cc_ctl_r[gc];
      end
   endgenerate

   // -----------------------------------------------------------------
   // read mux
   // -----------------------------------------------------------------

   // direction status follows the selected mode
   always_comb
   begin
      unique case (dir_sel_r)
         TCR_DIR_UP: updn_stat = 1'b1;
         TCR_DIR_DOWN: updn_stat = 1'b0;
         default: updn_stat = dir_up_r;
      endcase
   end

   // unmapped addresses answer zero with an error
   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      if (paddr == `TCR_OFS_CTL)
      begin
         rd_data[`TCR_CTL_PERIOD_LOAD_BUSY] = mc_busy; // see [R1]
         rd_data[`TCR_CTL_DIR_HI:`TCR_CTL_DIR_LO] = dir_sel_r;
         rd_data[`TCR_CTL_ONESHOT] = oneshot_r;
         rd_data[`TCR_CTL_RUN] = run_r; // see [R4]
         rd_data[`TCR_CTL_PRESET] = preset_r; // see [R8]
         rd_data[`TCR_CTL_EN] = channel_enable;
      end
      else if (paddr == `TCR_OFS_MC)
         rd_data[15:0] = mc_shadow_r;
      else if (paddr == `TCR_OFS_TC)
         rd_data[15:0] = current_count; // see [R13]
      else if (paddr == `TCR_OFS_CS)
      begin
         rd_data[`TCR_CS_CAP_HI:`TCR_CS_CAP_LO] = cap_level & `TCR_CAP_BUILT; // see [R14]
         rd_data[`TCR_CS_UPDN] = updn_stat; // see [R15]
         rd_data[`TCR_CS_BSY] = run_r; // see [R16]
      end
      else if (paddr == `TCR_OFS_INTF)
         rd_data[15:0] = flag_r; // see [R17]
      else if (paddr == `TCR_OFS_INTE)
         rd_data[15:0] = inte_r;
      else if (cc_hit && cc_idx < 3'd6 && paddr[1:0] == 2'b00)
         rd_data[15:0] = cc_ctl_r[cc_idx];
      else
         rd_err = 1'b1;
   end

   // -----------------------------------------------------------------
   // apb answer
   // -----------------------------------------------------------------

   // answer is staged in the setup cycle so every output is a flop;
   // costs nothing, the access phase still ends on its first edge
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h0000_0000 : rd_data;
         pslverr <= rd_err;
      end
      else
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

endmodule
`default_nettype wire

/* rtl/tcr_defs.svh */
// Operation
// [R1] period busy reads 1 while max loads
// [R2] direction field selects up, down, up/down
// [R3] run starts only with channel enable set
// [R4] run write 0 stops; reads counting state
// [R5] one-shot end clears run automatically
// [R6] preset clears counter in up modes
// [R7] preset loads max value in down mode
// [R8] preset reads 1 while reset pending
// [R9] channel enable gates clock, preset, run
// [R10] max period resets to ffff, never zero
// [R11] software keeps max fixed in one-shot run
// [R12] software holds enable until busy falls
// [R13] live counter readable, resets to zero
// [R14] status bits 2-7 show capture pin levels
// [R15] direction status 1 up, 0 down
// [R16] busy status bit 0 shows running
// [R17] flags set on cause, write 1 clears
// [R18] flag layout zero, max, per-circuit pairs
// [R19] absent circuit flags and enables read 0
// [R20] enable bits mirror flag bit positions
// [R21] software clears flag before enabling it
// [R22] request raised when enabled flag set
// [R23] max flag set when counter reaches max
// [R24] zero flag set when counter reaches zero
// [R25] count per tick, repeat mode wraps
`ifndef TCR_DEFS_SVH
`define TCR_DEFS_SVH

// -----------------------------------------------------------------
// register offsets (byte addresses)
// -----------------------------------------------------------------
`define TCR_OFS_CTL 12'h000
`define TCR_OFS_MC 12'h004
`define TCR_OFS_TC 12'h008
`define TCR_OFS_CS 12'h00c
`define TCR_OFS_INTF 12'h010
`define TCR_OFS_INTE 12'h014
`define TCR_OFS_CC_BASE 12'h020

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define TCR_CTL_EN 0
`define TCR_CTL_PRESET 1
`define TCR_CTL_RUN 2
`define TCR_CTL_ONESHOT 3
`define TCR_CTL_DIR_LO 4
`define TCR_CTL_DIR_HI 5
`define TCR_CTL_PERIOD_LOAD_BUSY 8
`define TCR_CS_BSY 0
`define TCR_CS_UPDN 1
`define TCR_CS_CAP_LO 2
`define TCR_CS_CAP_HI 7

// -----------------------------------------------------------------
// reset values and build masks
// -----------------------------------------------------------------
`define TCR_MC_RESET 16'hffff
`define TCR_TC_RESET 16'h0000
`define TCR_NUM_CC 6
`define TCR_CC_BUILT 6'h0f
`define TCR_CAP_BUILT 6'h0f
`define TCR_FLAG_BUILT 16'h03ff
`define TCR_CCCTL_MASK 16'hff7f

`endif

/* rtl/tcr_pkg.sv */
package tcr_pkg;
   // count direction field encodings
   typedef enum logic [1:0] {
      TCR_DIR_UP = 2'h0,
      TCR_DIR_DOWN = 2'h1,
      TCR_DIR_UPDN = 2'h2,
      TCR_DIR_RSVD = 2'h3
   } tcr_dir_t;
   // period loader states, one-hot
   typedef enum logic [1:0] {
      TCR_LD_IDLE = 2'b01,
      TCR_LD_BUSY = 2'b10
   } tcr_load_state_t;
endpackage

/* rtl/tcr_cap_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module tcr_cap_sync
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // raw pins and synchronised levels
   input wire logic [5:0] pin_async,
   output logic [5:0] pin_level
);
   // -----------------------------------------------------------------
   // two-stage synchroniser per pin
   // -----------------------------------------------------------------
   logic [5:0] meta_r; // first stage, read only by second stage
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1)
      begin : g_pin
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               meta_r[gi] <= 1'b0;
               pin_level[gi] <= 1'b0;
            end
            else
            begin
               meta_r[gi] <= pin_async[gi];
               pin_level[gi] <= meta_r[gi];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

/* rtl/tcr_period_load.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tcr_defs.svh"
module tcr_period_load
   import tcr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register write side
   input wire logic wr,
   input wire logic [15:0] wdata,
   input wire logic enable,
   input wire logic tick,
   // status and loaded value
   output logic busy,
   output logic [15:0] max_value
);
   // -----------------------------------------------------------------
   // load handshake: value moves into the counter domain on a tick
   // -----------------------------------------------------------------
   tcr_load_state_t st_r; // loader state
   logic [15:0] pend_r; // value waiting for a tick

   // the transfer only completes with the channel clock running
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_r <= TCR_LD_IDLE;
         pend_r <= `TCR_MC_RESET;
         busy <= 1'b0;
         max_value <= `TCR_MC_RESET; // see [R10]
      end
      else
      begin
         unique case (st_r)
            TCR_LD_IDLE:
            begin
               // writes during busy are dropped, not queued
               if (wr)
               begin
                  pend_r <= wdata;
                  st_r <= TCR_LD_BUSY;
                  busy <= 1'b1; // see [R1]
               end
            end
            TCR_LD_BUSY:
            begin
               if (tick && enable) // see [R12]
               begin
                  max_value <= pend_r;
                  st_r <= TCR_LD_IDLE;
                  busy <= 1'b0; // see [R1]
               end
            end
            default:
            begin
               st_r <= TCR_LD_IDLE;
               busy <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* verification/tcr_timer_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// port checker for the timer registers
// ----------------------------------------
module tcr_timer_asserts
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // counter side
   input wire logic count_tick,
   input wire logic channel_enable,
   input wire logic [15:0] current_count,
   input wire logic [95:0] cc_control
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // only a finished write may move control state
   logic wr_done;
   assign wr_done = psel && penable && pready && pwrite;
   // apb answer timing
   AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
      else $error("answer outside access phase");
   AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
      else $error("answer held too long");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("error without answer");
   AST_DATA_IDLE_ZERO: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0)
      else $error("upper read bits set");
   // counter moves only on an enabled tick
   AST_COUNT_NEEDS_TICK: assert property (!(count_tick && channel_enable) |=> $stable(current_count))
      else $error("count moved without enabled tick");
   // control outputs move only after a write
   AST_ENABLE_BY_WRITE: assert property (!wr_done |=> $stable(channel_enable))
      else $error("enable changed without write");
   AST_CC_BY_WRITE: assert property (!wr_done |=> $stable(cc_control))
      else $error("circuit control changed without write");
   AST_ABSENT_CC_ZERO: assert property (cc_control[95:64] == 32'h0)
      else $error("absent circuit control set");
endmodule
bind tcr_timer tcr_timer_asserts u_chk (.clk, .rst, .psel, .penable, .pwrite, .pready, .prdata,
   .pslverr, .count_tick, .channel_enable, .current_count, .cc_control);
`default_nettype wire

/* verification/tb_timer_counter_control_regs.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tcr_defs.svh"
// ----------------------------------------
// self-checking bench for the timer registers
// ----------------------------------------
module tb_timer_counter_control_regs;
   // bus and pin drive
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, count_tick = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [5:0] cc_event = 6'h00, cc_overwrite_event = 6'h00, capture_input_pin = 6'h00;
   // design outputs
   logic pready, pslverr, channel_enable, irq;
   logic [31:0] prdata;
   logic [15:0] current_count;
   logic [95:0] cc_control;
   // scoreboard notes hold {error, mask, data}
   logic [64:0] exp_q[$];
   logic [64:0] note;
   logic [31:0] rnd, v;
   int err_total = 0, total_checks = 0, cyc = 0;
   always #4 clk = ~clk;
   tcr_timer u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
      .count_tick, .cc_event, .cc_overwrite_event, .capture_input_pin, .channel_enable, .current_count,
      .cc_control, .irq);
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one transfer; request held until pready is seen high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
      rnd = $urandom();
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {rnd[31:16], d[15:0]};
      exp_q.push_back({e, m, d & m});
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
      apb(1'b0, a, d, m, 1'b0);
   endtask
   // divided clock pulses; trailing edges let flags and irq land
   task tick(input int n);
      repeat (n)
      begin
         @(posedge clk);
         count_tick <= 1'b1;
         @(posedge clk);
         count_tick <= 1'b0;
      end
      repeat (2) @(posedge clk);
   endtask
   task wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ----------------------------------------
   // watcher and timeout
   // ----------------------------------------
   always @(posedge clk)
      if (pready === 1'b1)
      begin
         note = exp_q.pop_front();
         chk(prdata & note[63:32], note[31:0]);
         chk({31'h0, pslverr}, {31'h0, note[64]});
      end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         wrap_up();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(32'h18ac9d68));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(`TCR_OFS_CTL, 32'h0, 32'hffffffff);
      rd(`TCR_OFS_MC, 32'hffff, 32'hffffffff);
      rd(`TCR_OFS_TC, 32'h0, 32'hffffffff);
      rd(`TCR_OFS_CS, 32'h2, 32'hffffffff);
      rd(`TCR_OFS_INTF, 32'h0, 32'hffffffff);
      rd(`TCR_OFS_INTE, 32'h0, 32'hffffffff);
      apb(1'b0, 12'h040, 32'h0, 32'hffffffff, 1'b1);
      apb(1'b1, 12'h0fc, 32'h0, 32'h0, 1'b1);
      // run refused while the channel is off
      wr(`TCR_OFS_CTL, 32'h4);
      tick(1);
      rd(`TCR_OFS_CTL, 32'h0, 32'hffff);
      rd(`TCR_OFS_TC, 32'h0, 32'hffff);
      // flags were read clear above, so enabling them raises nothing
      wr(`TCR_OFS_INTE, 32'hffff);
      rd(`TCR_OFS_INTE, 32'h03ff, 32'hffff);
      wr(`TCR_OFS_INTE, 32'h0);
      // period load shows busy until the next tick; enable goes first
      wr(`TCR_OFS_CTL, 32'h1);
      wr(`TCR_OFS_MC, 32'h5);
      chk({31'h0, channel_enable}, 32'h1);
      rd(`TCR_OFS_CTL, 32'h101, 32'hffff);
      tick(1);
      rd(`TCR_OFS_CTL, 32'h1, 32'hffff);
      // repeat up count, wrap, flags and request
      wr(`TCR_OFS_CTL, 32'h5);
      rd(`TCR_OFS_CS, 32'h3, 32'h3);
      tick(5);
      chk({16'h0, current_count}, 32'h5);
      tick(1);
      chk({16'h0, current_count}, 32'h0);
      rd(`TCR_OFS_INTF, 32'h3, 32'hffff);
      wr(`TCR_OFS_INTF, 32'h1);
      rd(`TCR_OFS_INTF, 32'h2, 32'hffff);
      wr(`TCR_OFS_INTE, 32'h2);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      wr(`TCR_OFS_INTF, 32'h2);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      tick(2);
      wr(`TCR_OFS_CTL, 32'h1);
      tick(2);
      rd(`TCR_OFS_CTL, 32'h1, 32'hffff);
      rd(`TCR_OFS_TC, 32'h2, 32'hffff);
      // preset in up and down, then one-shot down
      wr(`TCR_OFS_CTL, 32'h3);
      rd(`TCR_OFS_CTL, 32'h2, 32'h2);
      tick(1);
      rd(`TCR_OFS_CTL, 32'h0, 32'h2);
      rd(`TCR_OFS_TC, 32'h0, 32'hffff);
      wr(`TCR_OFS_CTL, 32'h13);
      tick(1);
      rd(`TCR_OFS_TC, 32'h5, 32'hffff);
      rd(`TCR_OFS_CS, 32'h0, 32'h3);
      // period left untouched while the one-shot runs
      wr(`TCR_OFS_CTL, 32'h1d);
      tick(6);
      rd(`TCR_OFS_CTL, 32'h19, 32'hffff);
      rd(`TCR_OFS_TC, 32'h0, 32'hffff);
      // up/down turns at the period, reserved mode holds
      wr(`TCR_OFS_CTL, 32'h23);
      tick(1);
      wr(`TCR_OFS_CTL, 32'h25);
      tick(6);
      rd(`TCR_OFS_TC, 32'h4, 32'hffff);
      rd(`TCR_OFS_CS, 32'h1, 32'h3);
      wr(`TCR_OFS_CTL, 32'h35);
      tick(2);
      rd(`TCR_OFS_TC, 32'h4, 32'hffff);
      wr(`TCR_OFS_CTL, 32'h0);
      // pin levels after the synchroniser, absent pins read 0
      repeat (3)
      begin
         v = $urandom();
         capture_input_pin <= v[5:0];
         repeat (4) @(posedge clk);
         rd(`TCR_OFS_CS, {26'h0, v[3:0], 2'h0}, 32'hfc);
      end
      chk({31'h0, channel_enable}, 32'h0);
      // circuit control words, absent circuits stay 0
      for (int m = 0; m < 6; m++)
      begin
         v = $urandom();
         wr(`TCR_OFS_CC_BASE + 12'(4 * m), v);
         rd(`TCR_OFS_CC_BASE + 12'(4 * m), m < 4 ? v & 32'hff7f : 32'h0, 32'hffffffff);
         chk({16'h0, cc_control[16 * m +: 16]}, m < 4 ? v & 32'hff7f : 32'h0);
      end
      // circuit causes land at their flag pairs
      @(posedge clk);
      cc_event <= 6'h3f;
      cc_overwrite_event <= 6'h3f;
      @(posedge clk);
      cc_event <= 6'h00;
      cc_overwrite_event <= 6'h00;
      rd(`TCR_OFS_INTF, 32'h03fc, 32'h3ffc);
      wr(`TCR_OFS_INTF, 32'hffff);
      rd(`TCR_OFS_INTF, 32'h0, 32'hffff);
      repeat (4) @(posedge clk);
      chk(exp_q.size(), 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
